// >>> cis_core_exec.sv
// executor for stack-relative, address, stack adjust, push/pop and multiple transfer formats
// How it works
// - stack-relative store writes destination word at stack pointer plus offset
// - stack-relative load reads word at stack pointer plus offset into destination
// - eight-bit offset field is scaled by four into a word-aligned value
// - address form with select low writes program counter plus offset
// - address form with select high writes stack pointer plus offset
// - program counter source is instruction address plus four, bit one cleared
// - address generation leaves the condition flags unchanged
// - stack adjust uses sign plus seven-bit magnitude scaled by four
// - sign set subtracts the magnitude from the stack pointer
// - stack adjust never touches condition flags
// - push predecrements, pop postincrements, final stack pointer written back
// - push with extra bit also stores link register above the list
// - pop with extra bit loads program counter last and branches
// - plain pop loads only listed registers, ascending, and updates stack pointer
// - multiple store writes listed registers upward from base, writes base back
// - multiple load reads listed registers upward from base, writes base back unless base is in the list
// - cycle counts match the equivalent full-width instructions
`timescale 1ns/10ps
`default_nettype none
module cis_core_exec
   import cis_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   input wire logic [31:0] instr_addr,
   input wire logic [3:0] flags_in,
   input wire logic flags_we,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack,
   output logic instr_ready,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   output logic done,
   output logic undef_instr,
   output logic branch,
   output logic [31:0] branch_target,
   output logic [3:0] status_flags,
   output logic [31:0] stack_pointer
);
   cis_dec_if d ();
   cis_state_t state_r, state_nxt;
   logic ready_r, req_r, we_r, done_r, undef_r, branch_r;
   logic [31:0] addr_r, wdata_r, target_r, wb_val_r;
   logic [31:0] addr_nxt, wdata_nxt, wb_val_nxt;
   logic [3:0] flags_r, cur_r, cur_nxt, wb_idx_r, wb_idx_nxt;
   logic [CIS_LIST_W-1:0] mask_r, mask_nxt;
   logic load_r, load_nxt, wb_en_r, wb_en_nxt;
   logic [1:0] tail_r, tail_nxt;
   logic req_nxt, done_nxt, branch_nxt;
   logic [3:0] ra_idx;
   logic [31:0] ra_data, rb_data, sp_data;
   logic w1_en, w2_en;
   logic [3:0] w1_idx;
   logic [31:0] w1_data;

   cis_decode u_dec (
      .instr(instr),
      .d(d.dec)
   );

   cis_regfile u_rf (
      .mclk(mclk),
      .resetn(resetn),
      .ce(ce),
      .ra_idx(ra_idx),
      .ra_data(ra_data),
      .rb_idx(d.base),
      .rb_data(rb_data),
      .sp_data(sp_data),
      .w1_en(w1_en),
      .w1_idx(w1_idx),
      .w1_data(w1_data),
      .w2_en(w2_en),
      .w2_idx(wb_idx_r),
      .w2_data(wb_val_r)
   );

   wire logic take = ce && ready_r && instr_valid;
   wire logic [31:0] off32 = {22'h0, d.off10};
   wire logic [31:0] span = {26'h0, d.cnt, 2'b00};
   wire logic [31:0] pc_src = (instr_addr + CIS_PC_AHEAD) & CIS_PC_BIT1_CLR;
   wire logic [31:0] adr_val = (d.sel ? sp_data : pc_src) + off32;
   wire logic [31:0] sprel_addr = sp_data + off32;
   wire logic [31:0] adj32 = {23'h0, d.adj_mag};
   wire logic [31:0] sp_adj = d.adj_neg ? sp_data - adj32 : sp_data + adj32;
   wire logic is_pp = d.kind == CIS_K_PUSHPOP;
   wire logic [31:0] list_base = is_pp ? sp_data : rb_data;
   wire logic [31:0] list_start = (is_pp && !d.load) ? sp_data - span : list_base;
   wire logic [31:0] list_final = (is_pp && !d.load) ? sp_data - span : list_base + span;
   wire logic xfer_last = state_r == CIS_XFER && mem_ack && mask_r == '0;
   wire logic [3:0] first_bit = cis_lowest(d.mask);
   wire logic [3:0] next_bit = cis_lowest(mask_r);
   // bit 8 of the list names the link register on a push, the program counter on a pop
   wire logic [3:0] first_idx = first_bit[3] ? (d.load ? CIS_PC_IDX : CIS_LR_IDX) : first_bit;
   wire logic [3:0] next_idx = next_bit[3] ? (load_r ? CIS_PC_IDX : CIS_LR_IDX) : next_bit;

   assign ra_idx = (state_r == CIS_IDLE) ? (d.kind == CIS_K_SPREL ? {1'b0, d.rd} : first_idx) : next_idx;
   assign w1_en = ce && ((take && (d.kind == CIS_K_ADR || d.kind == CIS_K_ADDSP)) ||
                  (state_r == CIS_XFER && mem_ack && load_r && cur_r != CIS_PC_IDX));
   assign w1_idx = (state_r == CIS_XFER) ? cur_r : (d.kind == CIS_K_ADDSP ? CIS_SP_IDX : {1'b0, d.rd});
   assign w1_data = (state_r == CIS_XFER) ? mem_rdata : (d.kind == CIS_K_ADDSP ? sp_adj : adr_val);
   assign w2_en = ce && xfer_last && wb_en_r;

   always_comb
   begin
      state_nxt = state_r;
      req_nxt = req_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      cur_nxt = cur_r;
      mask_nxt = mask_r;
      load_nxt = load_r;
      wb_en_nxt = wb_en_r;
      wb_idx_nxt = wb_idx_r;
      wb_val_nxt = wb_val_r;
      tail_nxt = tail_r;
      done_nxt = 1'b0;
      branch_nxt = 1'b0;
      case (state_r)
         CIS_IDLE:
         begin
            if (take)
            begin
               load_nxt = d.load;
               wdata_nxt = ra_data;
               case (d.kind)
                  CIS_K_SPREL:
                  begin
                     state_nxt = CIS_XFER;
                     req_nxt = 1'b1;
                     addr_nxt = sprel_addr;
                     cur_nxt = {1'b0, d.rd};
                     mask_nxt = '0;
                     wb_en_nxt = 1'b0;
                     tail_nxt = d.load ? CIS_TAIL_LOAD : 2'h0;
                  end
                  CIS_K_PUSHPOP, CIS_K_MULTI:
                  begin
                     if (d.cnt != 4'h0)
                     begin
                        state_nxt = CIS_XFER;
                        req_nxt = 1'b1;
                        addr_nxt = list_start;
                        cur_nxt = first_idx;
                        mask_nxt = d.mask & ~(CIS_LIST_W'(1) << first_bit);
                        // a loaded base keeps its loaded value
                        wb_en_nxt = is_pp || !(d.load && d.mask[d.base[2:0]]);
                        wb_idx_nxt = is_pp ? CIS_SP_IDX : d.base;
                        wb_val_nxt = list_final;
                        tail_nxt = d.load ? ((is_pp && d.mask[CIS_EXTRA_BIT]) ?
                                   CIS_TAIL_LOAD + CIS_TAIL_PC : CIS_TAIL_LOAD) : 2'h0;
                     end
                     else
                        done_nxt = 1'b1;
                  end
                  default:
                     done_nxt = 1'b1;
               endcase
            end
         end
         CIS_XFER:
         begin
            if (mem_ack)
            begin
               if (load_r && cur_r == CIS_PC_IDX)
                  branch_nxt = 1'b1;
               if (mask_r == '0)
               begin
                  req_nxt = 1'b0;
                  state_nxt = (tail_r == 2'h0) ? CIS_IDLE : CIS_TAIL;
                  done_nxt = tail_r == 2'h0;
               end
               else
               begin
                  addr_nxt = addr_r + CIS_WORD_STEP;
                  cur_nxt = next_idx;
                  wdata_nxt = ra_data;
                  mask_nxt = mask_r & ~(CIS_LIST_W'(1) << next_bit);
               end
            end
         end
         CIS_TAIL:
         begin
            tail_nxt = tail_r - 2'h1;
            if (tail_r == 2'h1)
            begin
               state_nxt = CIS_IDLE;
               done_nxt = 1'b1;
            end
         end
         default:
            state_nxt = CIS_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r <= CIS_IDLE;
         ready_r <= 1'b1;
         req_r <= 1'b0;
         we_r <= 1'b0;
         addr_r <= 32'h0;
         wdata_r <= 32'h0;
         cur_r <= 4'h0;
         mask_r <= '0;
         load_r <= 1'b0;
         wb_en_r <= 1'b0;
         wb_idx_r <= 4'h0;
         wb_val_r <= 32'h0;
         tail_r <= 2'h0;
         done_r <= 1'b0;
         undef_r <= 1'b0;
         branch_r <= 1'b0;
         target_r <= 32'h0;
      end
      else if (ce)
      begin
         state_r <= state_nxt;
         ready_r <= state_nxt == CIS_IDLE;
         req_r <= req_nxt;
         we_r <= req_nxt && !load_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         cur_r <= cur_nxt;
         mask_r <= mask_nxt;
         load_r <= load_nxt;
         wb_en_r <= wb_en_nxt;
         wb_idx_r <= wb_idx_nxt;
         wb_val_r <= wb_val_nxt;
         tail_r <= tail_nxt;
         done_r <= done_nxt;
         undef_r <= take && d.kind == CIS_K_NONE;
         branch_r <= branch_nxt;
         if (branch_nxt)
            target_r <= mem_rdata & CIS_HALF_ALIGN;
      end
   end

   // only the outside core writes the flags; none of these formats do
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         flags_r <= CIS_FLAGS_RST;
      else if (ce && flags_we)
         flags_r <= flags_in;
   end

   assign instr_ready = ready_r;
   assign mem_req = req_r;
   assign mem_we = we_r;
   assign mem_addr = addr_r;
   assign mem_wdata = wdata_r;
   assign done = done_r;
   assign undef_instr = undef_r;
   assign branch = branch_r;
   assign branch_target = target_r;
   assign status_flags = flags_r;
   assign stack_pointer = sp_data;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   a_str_word_addr: assert property (
      take && d.kind == CIS_K_SPREL && !d.load |=> mem_req && mem_we && mem_addr == $past(sprel_addr))
      else $error("stack-relative store address wrong");
   a_ldr_word_read: assert property (
      take && d.kind == CIS_K_SPREL && d.load |=> mem_req && !mem_we && mem_addr == $past(sprel_addr))
      else $error("stack-relative load not issued");
   a_offset_scaled: assert property (
      take && d.kind == CIS_K_SPREL |=> mem_addr - $past(sp_data) == {22'h0, $past(instr[7:0]), 2'b00})
      else $error("offset not scaled by four");
   a_adr_pc_value: assert property (
      take && d.kind == CIS_K_ADR && !d.sel |-> w1_en && w1_idx == {1'b0, d.rd} &&
      w1_data == ((instr_addr + 32'h4) & 32'hffff_fffd) + off32)
      else $error("pc-relative address wrong");
   a_adr_sp_value: assert property (
      take && d.kind == CIS_K_ADR && d.sel |-> w1_en && w1_data == sp_data + off32)
      else $error("sp-relative address wrong");
   a_flags_kept: assert property (
      !flags_we && ce |=> status_flags == $past(status_flags))
      else $error("flags changed without outside write");
   a_addsp_sign: assert property (
      take && d.kind == CIS_K_ADDSP |=> stack_pointer ==
      ($past(d.adj_neg) ? $past(sp_data) - $past(adj32) : $past(sp_data) + $past(adj32)))
      else $error("stack adjust wrong");
   a_push_predec: assert property (
      take && is_pp && !d.load && d.cnt != 4'h0 |=> mem_addr == $past(sp_data) - $past(span))
      else $error("push start address wrong");
   a_list_ascend: assert property (
      ce && state_r == CIS_XFER && mem_ack && mask_r != '0 |=> mem_addr == $past(mem_addr) + 32'h4)
      else $error("transfer address not ascending");
   a_pop_branch: assert property (
      ce && state_r == CIS_XFER && mem_ack && load_r && cur_r == CIS_PC_IDX |=> branch ##1 !branch)
      else $error("pc pop did not branch");
   a_str_cycles: assert property (
      take && d.kind == CIS_K_SPREL && !d.load ##1 ce && mem_ack |=> done && instr_ready)
      else $error("store word took wrong cycle count");

   c_push_lr: cover property (take && is_pp && !d.load && d.mask[CIS_EXTRA_BIT]);
   c_pop_pc: cover property (branch);
   c_multi_load: cover property (take && d.kind == CIS_K_MULTI && d.load && d.cnt > 4'h2);
   c_addsp_neg: cover property (take && d.kind == CIS_K_ADDSP && d.adj_neg);
endmodule // cis_core_exec
`default_nettype wire

// >>> cis_dec_if.sv
// decoded instruction fields passed from the decoder to the executor
`timescale 1ns/10ps
`default_nettype none
interface cis_dec_if;
   import cis_pkg::*;
   cis_kind_t kind;
   logic load;
   logic sel;
   logic [2:0] rd;
   logic [3:0] base;
   logic [9:0] off10;
   logic [8:0] adj_mag;
   logic adj_neg;
   logic [CIS_LIST_W-1:0] mask;
   logic [3:0] cnt;
   modport dec (output kind, load, sel, rd, base, off10, adj_mag, adj_neg, mask, cnt);
   modport exe (input kind, load, sel, rd, base, off10, adj_mag, adj_neg, mask, cnt);
endinterface
`default_nettype wire

// >>> cis_decode.sv
// combinational field decoder for the five compact formats
`timescale 1ns/10ps
`default_nettype none
module cis_decode
   import cis_pkg::*;
(
   input wire logic [15:0] instr,
   cis_dec_if.dec d
);
   wire logic [3:0] op = instr[15:12];
   wire logic is_addsp = (op == CIS_OP_MISC) && (instr[11:8] == CIS_ADDSP_TAG);
   wire logic is_pp = (op == CIS_OP_MISC) && (instr[10:9] == CIS_PUSHPOP_TAG);
   wire logic extra = is_pp && instr[CIS_EXTRA_BIT];
   logic [3:0] cnt_sum;

   assign d.kind = (op == CIS_OP_SPREL) ? CIS_K_SPREL :
                   (op == CIS_OP_ADR) ? CIS_K_ADR :
                   is_addsp ? CIS_K_ADDSP :
                   is_pp ? CIS_K_PUSHPOP :
                   (op == CIS_OP_MULTI) ? CIS_K_MULTI : CIS_K_NONE;
   assign d.load = instr[CIS_L_BIT];
   assign d.sel = instr[CIS_L_BIT];
   assign d.rd = instr[CIS_RD_LSB +: 3];
   assign d.base = {1'b0, instr[CIS_RD_LSB +: 3]};
   assign d.off10 = {instr[7:0], 2'b00};
   assign d.adj_mag = {instr[6:0], 2'b00};
   assign d.adj_neg = instr[CIS_ADJ_SIGN_BIT];
   assign d.mask = {extra, instr[7:0]};
   assign d.cnt = cnt_sum;

   always_comb
   begin
      cnt_sum = 4'h0;
      for (int i = 0; i < CIS_LIST_W; i++)
      begin
         cnt_sum = cnt_sum + {3'b000, d.mask[i]};
      end
   end
endmodule // cis_decode
`default_nettype wire

// >>> cis_mem_model.sv
// memory partner on the load/store port, with optional random wait states
`timescale 1ns/10ps
`default_nettype none
module cis_mem_model
(
   input wire logic mclk,
   input wire logic slow,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [31:0] mem [0:1023];

   initial
   begin
      for (int i = 0; i < 1024; i++)
         mem[i] = {i[15:0] ^ 16'h5a3c, ~i[15:0]};
      mem_ack = 1'b0;
      mem_rdata = 32'h0;
   end

   // answer off the sampling edge; data not acked keeps toggling so stale reads show
   always @(negedge mclk)
   begin
      mem_ack = mem_req && (!slow || ($urandom % 3 == 0));
      mem_rdata = mem_ack ? mem[mem_addr[11:2]] : ~mem_rdata;
   end

   // upper address bits alias, the bench indexes the same way
   always @(posedge mclk)
   begin
      if (mem_req && mem_ack && mem_we)
         mem[mem_addr[11:2]] <= mem_wdata;
   end
endmodule // cis_mem_model
`default_nettype wire

// >>> cis_pkg.sv
// shared constants, types and helpers for the compact stack and multi-transfer executor
package cis_pkg;
   localparam int CIS_OP_LSB = 12;
   localparam int CIS_L_BIT = 11;
   localparam int CIS_RD_LSB = 8;
   localparam int CIS_EXTRA_BIT = 8;
   localparam int CIS_ADJ_SIGN_BIT = 7;
   localparam int CIS_SCALE_SH = 2;
   localparam int CIS_LIST_W = 9;
   localparam logic [3:0] CIS_OP_SPREL = 4'h9;
   localparam logic [3:0] CIS_OP_ADR = 4'ha;
   localparam logic [3:0] CIS_OP_MISC = 4'hb;
   localparam logic [3:0] CIS_OP_MULTI = 4'hc;
   localparam logic [3:0] CIS_ADDSP_TAG = 4'h0;
   localparam logic [1:0] CIS_PUSHPOP_TAG = 2'h2;
   localparam logic [3:0] CIS_SP_IDX = 4'hd;
   localparam logic [3:0] CIS_LR_IDX = 4'he;
   localparam logic [3:0] CIS_PC_IDX = 4'hf;
   localparam logic [31:0] CIS_WORD_STEP = 32'h4;
   localparam logic [31:0] CIS_PC_AHEAD = 32'h4;
   localparam logic [31:0] CIS_PC_BIT1_CLR = 32'hffff_fffd;
   localparam logic [31:0] CIS_HALF_ALIGN = 32'hffff_fffe;
   localparam logic [31:0] CIS_SP_RST = 32'h0;
   localparam logic [31:0] CIS_REG_RST = 32'h0;
   localparam logic [3:0] CIS_FLAGS_RST = 4'h0;
   localparam logic [1:0] CIS_TAIL_LOAD = 2'h1;
   localparam logic [1:0] CIS_TAIL_PC = 2'h2;

   typedef enum logic [2:0] {CIS_K_NONE, CIS_K_SPREL, CIS_K_ADR, CIS_K_ADDSP, CIS_K_PUSHPOP, CIS_K_MULTI} cis_kind_t;
   typedef enum logic [1:0] {CIS_IDLE, CIS_XFER, CIS_TAIL} cis_state_t;

   // lowest set bit of a list, as a bit number
   function automatic logic [3:0] cis_lowest(input logic [CIS_LIST_W-1:0] m);
      logic [3:0] r;
      r = 4'h0;
      for (int i = CIS_LIST_W - 1; i >= 0; i--)
      begin
         if (m[i])
            r = 4'(i);
      end
      return r;
   endfunction
endpackage

// >>> cis_regfile.sv
// low registers, stack pointer and link register with three read and two write ports
`timescale 1ns/10ps
`default_nettype none
module cis_regfile
   import cis_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [3:0] ra_idx,
   output logic [31:0] ra_data,
   input wire logic [3:0] rb_idx,
   output logic [31:0] rb_data,
   output logic [31:0] sp_data,
   input wire logic w1_en,
   input wire logic [3:0] w1_idx,
   input wire logic [31:0] w1_data,
   input wire logic w2_en,
   input wire logic [3:0] w2_idx,
   input wire logic [31:0] w2_data
);
   logic [31:0] regs_r [16];

   assign ra_data = regs_r[ra_idx];
   assign rb_data = regs_r[rb_idx];
   assign sp_data = regs_r[CIS_SP_IDX];

   generate
      for (genvar g = 0; g < 16; g++)
      begin : g_reg
         // port 1 wins so a loaded value beats a base write-back
         always_ff @(posedge mclk or negedge resetn)
         begin
            if (!resetn)
               regs_r[g] <= (g == CIS_SP_IDX) ? CIS_SP_RST : CIS_REG_RST;
            else if (ce && w1_en && w1_idx == 4'(g))
               regs_r[g] <= w1_data;
            else if (ce && w2_en && w2_idx == 4'(g))
               regs_r[g] <= w2_data;
         end
      end
   endgenerate
endmodule // cis_regfile
`default_nettype wire

// >>> compact_isa_stack_and_multi_xfer_bench.sv
// self-checking bench for the compact stack and multi-transfer executor
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module compact_isa_stack_and_multi_xfer_bench;
   typedef struct packed {logic [31:0] a; logic w; logic [31:0] d;} cis_beat_t;
   logic mclk, resetn, ce, instr_valid, flags_we, slow, mem_ack;
   logic [15:0] instr;
   logic [31:0] instr_addr, mem_rdata, mem_addr, mem_wdata, branch_target, stack_pointer;
   logic [3:0] flags_in, status_flags, ef;
   logic instr_ready, mem_req, mem_we, done, undef_instr, branch;
   logic [31:0] er [0:15];
   cis_beat_t bq [$];
   logic [31:0] brq [$];
   cis_beat_t b;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;

   cis_core_exec u_dut (.mclk(mclk), .resetn(resetn), .ce(ce), .instr_valid(instr_valid), .instr(instr),
      .instr_addr(instr_addr), .flags_in(flags_in), .flags_we(flags_we), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .instr_ready(instr_ready), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .done(done), .undef_instr(undef_instr), .branch(branch),
      .branch_target(branch_target), .status_flags(status_flags), .stack_pointer(stack_pointer));

   cis_mem_model u_mem (.mclk(mclk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // hang guard, generous against roughly 500 cycles of traffic
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         $display("unexpected timeout exp done got none");
         conclude();
      end
   end

   // watcher: every completed word and every branch takes the oldest note
   always @(posedge mclk)
   begin
      if (resetn === 1'b1 && mem_req === 1'b1 && mem_ack === 1'b1)
      begin
         if (bq.size() == 0)
            `CHK("beat queue", 1'b1, 1'b0)
         else
         begin
            b = bq.pop_front();
            `CHK("mem_addr", b.a, mem_addr)
            `CHK("mem_we", b.w, mem_we)
            if (b.w)
               `CHK("mem_wdata", b.d, mem_wdata)
         end
      end
      if (resetn === 1'b1 && branch === 1'b1)
      begin
         if (brq.size() == 0)
            `CHK("branch queue", 1'b1, 1'b0)
         else
            `CHK("branch_target", brq.pop_front(), branch_target)
      end
   end

   task automatic run(input logic [15:0] ins, input logic [31:0] ia, input int ncyc, input logic uexp);
      int cnt;
      cnt = 0;
      @(negedge mclk);
      instr = ins;
      instr_addr = ia;
      instr_valid = 1'b1;
      while (instr_ready !== 1'b1 && cnt < 50)
      begin
         @(negedge mclk);
         cnt++;
      end
      @(negedge mclk);
      instr_valid = 1'b0;
      cnt = 1;
      while (done !== 1'b1 && cnt < 400)
      begin
         @(negedge mclk);
         cnt++;
      end
      `CHK("done", 1'b1, done)
      `CHK("undef_instr", uexp, undef_instr)
      if (!slow)
         `CHK("cycles", ncyc, cnt)
      `CHK("stack_pointer", er[13], stack_pointer)
      `CHK("status_flags", ef, status_flags)
   endtask

   task automatic beat(input logic w, input logic [31:0] a, input int r);
      logic [31:0] d;
      d = w ? er[r] : u_mem.mem[a[11:2]];
      bq.push_back({a, w, d});
      if (!w && r == 15)
         brq.push_back(d & 32'hffff_fffe);
      else if (!w)
         er[r] = d;
   endtask

   task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] lst, input int extra);
      for (int i = 0; i < 8; i++)
      begin
         if (lst[i])
         begin
            beat(w, a, i);
            a += 32'h4;
         end
      end
      if (extra > 0)
         beat(w, a, extra);
   endtask

   task automatic pp(input logic l, input logic x, input logic [7:0] lst);
      int n;
      logic [31:0] a;
      n = $countones(lst);
      a = l ? er[13] : er[13] - 32'(4 * (n + x));
      xfer(!l, a, lst, x ? (l ? 15 : 14) : 0);
      if (n + x > 0)
         er[13] = l ? a + 32'(4 * (n + x)) : a;
      // a pc pop moves n plus one words and then idles three tail cycles
      run({4'hb, l, 2'b10, x, lst}, 32'h0, (n + x == 0) ? 1 : (l ? n + (x ? 5 : 2) : n + x + 1), 1'b0);
   endtask

   task automatic mx(input logic l, input logic [2:0] rb, input logic [7:0] lst);
      int n;
      logic [31:0] a;
      if (!l)
         lst[rb] = 1'b0;
      n = $countones(lst);
      a = er[rb];
      xfer(!l, a, lst, 0);
      if (n > 0 && !(l && lst[rb]))
         er[rb] = a + 32'(4 * n);
      run({4'hc, l, rb, lst}, 32'h0, (n == 0) ? 1 : n + 1 + int'(l), 1'b0);
   endtask

   task automatic sr(input logic l, input logic [2:0] rd, input logic [7:0] w8);
      beat(!l, er[13] + {22'h0, w8, 2'b00}, int'(rd));
      run({4'h9, l, rd, w8}, 32'h0, l ? 3 : 2, 1'b0);
   endtask

   // address result is only visible through a store that follows
   task automatic ad(input logic s, input logic [2:0] rd, input logic [7:0] w8, input logic [31:0] ia);
      er[rd] = (s ? er[13] : ((ia + 32'h4) & 32'hffff_fffd)) + {22'h0, w8, 2'b00};
      run({4'ha, s, rd, w8}, ia, 1, 1'b0);
      sr(1'b0, rd, 8'h00);
   endtask

   task automatic adj(input logic s, input logic [6:0] m);
      er[13] = s ? er[13] - {23'h0, m, 2'b00} : er[13] + {23'h0, m, 2'b00};
      run({8'hb0, s, m}, 32'h0, 1, 1'b0);
   endtask

   task automatic setf();
      @(negedge mclk);
      flags_in = 4'($urandom);
      flags_we = 1'b1;
      ef = flags_in;
      @(negedge mclk);
      flags_we = 1'b0;
      flags_in = ~flags_in;
   endtask

   initial
   begin
      void'($urandom(32'hb1233140));
      resetn = 1'b0;
      ce = 1'b1;
      instr_valid = 1'b0;
      instr = 16'h0;
      instr_addr = 32'h0;
      flags_in = 4'h0;
      flags_we = 1'b0;
      slow = 1'b0;
      ef = 4'h0;
      for (int i = 0; i < 16; i++)
         er[i] = 32'h0;
      repeat (8) @(negedge mclk);
      resetn = 1'b1;
      `CHK("stack_pointer", 32'h0, stack_pointer)
      setf();
      adj(1'b0, 7'h7f);
      adj(1'b1, 7'h7f);
      adj(1'b1, 7'h1a);
      adj(1'b0, 7'h43);
      for (int i = 0; i < 4; i++)
         adj(1'($urandom), 7'($urandom));
      pp(1'b1, 1'b0, 8'hff);
      pp(1'b0, 1'b1, 8'hff);
      pp(1'b0, 1'b1, 8'h00);
      pp(1'b1, 1'b0, 8'h00);
      sr(1'b0, 3'h4, 8'd123);
      sr(1'b0, 3'h0, 8'hff);
      for (int i = 0; i < 6; i++)
         sr(1'($urandom), 3'($urandom), 8'($urandom));
      ad(1'b0, 3'h2, 8'd143, 32'h0000_1006);
      for (int i = 0; i < 6; i++)
         ad(1'($urandom), 3'($urandom), 8'($urandom), $urandom & 32'hffff_fffe);
      for (int i = 0; i < 6; i++)
         mx(1'($urandom), 3'($urandom), 8'($urandom));
      mx(1'b1, 3'h3, 8'h0c);
      mx(1'b0, 3'h1, 8'h00);
      pp(1'b1, 1'b1, 8'($urandom));
      pp(1'b1, 1'b1, 8'h00);
      setf();
      slow = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         pp(1'b0, 1'b1, 8'($urandom));
         pp(1'b1, 1'b1, 8'($urandom));
         mx(1'($urandom), 3'($urandom), 8'($urandom));
         sr(1'($urandom), 3'($urandom), 8'($urandom));
      end
      slow = 1'b0;
      run(16'he000, 32'h0, 1, 1'b1);
      `CHK("beats left", 0, bq.size())
      `CHK("branches left", 0, brq.size())
      conclude();
   end
endmodule // compact_isa_stack_and_multi_xfer_bench
`default_nettype wire
